/* ctrl_one_pkg.sv */
package ctrl_one_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL_ONE_OFS  = 8'h00;
  localparam logic [7:0] B_CTRL_ONE_OFS  = 8'h20;
  localparam logic [7:0] A_RESET_VALUE   = 8'h00;
  localparam logic [7:0] B_RESET_VALUE   = 8'h02;
  localparam logic [7:0] NO_REG_VALUE    = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int INIT_BIT      = 7;
  localparam int NOISE_OFF_BIT = 6;
  localparam int B2B_BIT       = 5;
  localparam int PAD_BIT       = 4;
  localparam int BYPASS_BIT    = 3;
  localparam int FREEZE_BIT    = 2;
  localparam int FIXED_BIT     = 1;
  localparam int CASCADE_BIT   = 0;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int INIT_CYCLES   = 16;
  localparam int INIT_CNT_W    = 5;
  localparam int COEF_TAPS     = 8;
endpackage : ctrl_one_pkg

/* coef_mem.sv */
`timescale 1ns/10ps
// Small coefficient store with registered read and bulk clear
module coef_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW    = 3
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Access
  input  wire logic             clear,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ------------------------------------------------------------
  // Storage, one entry per generate step
  // ------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk) begin
      if (rst || clear) begin
        mem_reg[i] <= '0;
      end else if (wr_en && addr == AW'(i)) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  // Registered read port, forced to zero while the store is being cleared
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[addr];
    end
  end
endmodule : coef_mem

/* echo_group_control_reg1.sv */
`timescale 1ns/10ps
// Functional notes
// - Writing one to bit 7 runs initialisation; all settings and the bit return to the copy's reset value.
// - Bit 6 high stops noise injection; low keeps it on.
// - Bit 5 high selects back-to-back configuration; low selects normal.
// - Bit 4 high adds 12dB attenuation on receive path.
// - Bit 3 high passes send and receive data straight through.
// - During bypass coefficients are held zero and adaptation halts.
// - Bit 2 high freezes adaptation; cancelling continues with old coefficients.
// - Copy A bit 0 high cascades both cancellers into one 128ms canceller.
module echo_group_control_reg1 #(
  parameter int INIT_LEN = ctrl_one_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Canceller A controls
  output logic            a_init_busy,
  output logic            a_noise_injection_off,
  output logic            a_back_to_back_select,
  output logic            a_rx_pad_on,
  output logic            a_bypass,
  output logic            a_adapt_freeze,
  output logic            a_adapt_enable,
  output logic            a_coef_clear,
  // Canceller B controls
  output logic            b_init_busy,
  output logic            b_noise_injection_off,
  output logic            b_back_to_back_select,
  output logic            b_rx_pad_on,
  output logic            b_bypass,
  output logic            b_adapt_freeze,
  output logic            b_adapt_enable,
  output logic            b_coef_clear,
  // Group mode
  output logic            extended_delay_cascade,
  // Coefficient store access (canceller A)
  input  wire logic       coef_wr,
  input  wire logic [2:0] coef_addr,
  input  wire logic [15:0] coef_wdata,
  output logic      [15:0] coef_rdata
);
  logic [7:0] a_reg;
  logic [7:0] b_reg;
  logic [ctrl_one_pkg::INIT_CNT_W-1:0] a_cnt_reg;
  logic [ctrl_one_pkg::INIT_CNT_W-1:0] b_cnt_reg;
  logic       a_hit;
  logic       b_hit;

  assign a_hit = reg_wr && reg_addr == ctrl_one_pkg::A_CTRL_ONE_OFS;
  assign b_hit = reg_wr && reg_addr == ctrl_one_pkg::B_CTRL_ONE_OFS;

  // ------------------------------------------------------------
  // Control register copy A
  // ------------------------------------------------------------
  // Init bit stays set while the sequence runs, then all return to reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      a_reg <= ctrl_one_pkg::A_RESET_VALUE;
    end else if (a_reg[ctrl_one_pkg::INIT_BIT]) begin
      if (a_cnt_reg == ctrl_one_pkg::INIT_CNT_W'(INIT_LEN - 1)) begin
        a_reg <= ctrl_one_pkg::A_RESET_VALUE;
      end
    end else if (a_hit) begin
      a_reg <= reg_wdata;
    end
  end

  // Init sequence counter A
  always_ff @(posedge sys_clk) begin
    if (rst || !a_reg[ctrl_one_pkg::INIT_BIT]) begin
      a_cnt_reg <= '0;
    end else begin
      a_cnt_reg <= a_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Control register copy B
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_reg <= ctrl_one_pkg::B_RESET_VALUE;
    end else if (b_reg[ctrl_one_pkg::INIT_BIT]) begin
      if (b_cnt_reg == ctrl_one_pkg::INIT_CNT_W'(INIT_LEN - 1)) begin
        b_reg <= ctrl_one_pkg::B_RESET_VALUE;
      end
    end else if (b_hit) begin
      b_reg <= reg_wdata;
    end
  end

  // Init sequence counter B
  always_ff @(posedge sys_clk) begin
    if (rst || !b_reg[ctrl_one_pkg::INIT_BIT]) begin
      b_cnt_reg <= '0;
    end else begin
      b_cnt_reg <= b_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= ctrl_one_pkg::NO_REG_VALUE;
    end else if (reg_rd && reg_addr == ctrl_one_pkg::A_CTRL_ONE_OFS) begin
      reg_rdata <= a_reg;
    end else if (reg_rd && reg_addr == ctrl_one_pkg::B_CTRL_ONE_OFS) begin
      reg_rdata <= b_reg;
    end else begin
      reg_rdata <= ctrl_one_pkg::NO_REG_VALUE;
    end
  end

  // ------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------
  // Canceller A
  assign a_init_busy           = a_reg[ctrl_one_pkg::INIT_BIT];
  assign a_noise_injection_off = a_reg[ctrl_one_pkg::NOISE_OFF_BIT];
  assign a_back_to_back_select = a_reg[ctrl_one_pkg::B2B_BIT];
  assign a_rx_pad_on           = a_reg[ctrl_one_pkg::PAD_BIT];
  assign a_bypass              = a_reg[ctrl_one_pkg::BYPASS_BIT];
  assign a_adapt_freeze        = a_reg[ctrl_one_pkg::FREEZE_BIT];
  assign a_coef_clear          = a_bypass;
  assign a_adapt_enable        = !a_bypass && !a_adapt_freeze;
  // Canceller B
  assign b_init_busy           = b_reg[ctrl_one_pkg::INIT_BIT];
  assign b_noise_injection_off = b_reg[ctrl_one_pkg::NOISE_OFF_BIT];
  assign b_back_to_back_select = b_reg[ctrl_one_pkg::B2B_BIT];
  assign b_rx_pad_on           = b_reg[ctrl_one_pkg::PAD_BIT];
  assign b_bypass              = b_reg[ctrl_one_pkg::BYPASS_BIT];
  assign b_adapt_freeze        = b_reg[ctrl_one_pkg::FREEZE_BIT];
  assign b_coef_clear          = b_bypass;
  assign b_adapt_enable        = !b_bypass && !b_adapt_freeze;
  // Cascade comes only from copy A; copy B bit 0 is ignored
  assign extended_delay_cascade = a_reg[ctrl_one_pkg::CASCADE_BIT];

  // ------------------------------------------------------------
  // Coefficient store, cleared and write-locked in bypass
  // ------------------------------------------------------------
  coef_mem #(
    .DEPTH (ctrl_one_pkg::COEF_TAPS),
    .WIDTH (16),
    .AW    (3)
  ) u_coef (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (a_coef_clear),
    .wr_en   (coef_wr && a_adapt_enable),
    .addr    (coef_addr),
    .wr_data (coef_wdata),
    .rd_data (coef_rdata)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_init_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(a_reg[7]) |-> ##INIT_LEN (a_reg == ctrl_one_pkg::A_RESET_VALUE))
    else $error("init bit A did not self clear");
  a_write_stores: assert property (@(posedge sys_clk) disable iff (rst)
    (a_hit && !a_reg[7]) |=> (a_reg == $past(reg_wdata)))
    else $error("write to A not stored");
  a_read_data: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == 8'h20) |=> (reg_rdata == $past(b_reg)))
    else $error("read of B wrong");
  a_noise_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (b_hit && !b_reg[7]) |=> (b_noise_injection_off == $past(reg_wdata[6])))
    else $error("noise control B wrong");
  a_b2b_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (a_hit && !a_reg[7]) |=> (a_back_to_back_select == $past(reg_wdata[5])))
    else $error("back to back A wrong");
  a_pad_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (a_hit && !a_reg[7]) |=> (a_rx_pad_on == $past(reg_wdata[4])))
    else $error("pad A wrong");
  a_bypass_halts: assert property (@(posedge sys_clk) disable iff (rst)
    a_bypass |-> !a_adapt_enable ##1 (coef_rdata == 16'h0000))
    else $error("bypass did not clear coefficients");
  a_bypass_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (b_hit && !b_reg[7]) |=> (b_bypass == $past(reg_wdata[3])))
    else $error("bypass B wrong");
  a_freeze_holds: assert property (@(posedge sys_clk) disable iff (rst)
    a_adapt_freeze |-> !a_adapt_enable)
    else $error("freeze did not stop adaptation");
  a_cascade_src: assert property (@(posedge sys_clk) disable iff (rst)
    (a_hit && !a_reg[7]) |=> (extended_delay_cascade == $past(reg_wdata[0])))
    else $error("cascade not from copy A");

  c_init_run:  cover property (@(posedge sys_clk) $rose(a_reg[7]));
  c_bypass_on: cover property (@(posedge sys_clk) $rose(b_bypass));
  c_cascade:   cover property (@(posedge sys_clk) $rose(extended_delay_cascade));
endmodule : echo_group_control_reg1

/* test_echo_group_control_reg1.sv */
`timescale 1ns/10ps
module test_echo_group_control_reg1;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, coef_wr = 1'b0;
  logic [2:0]  coef_addr = 3'h0;
  logic [15:0] coef_wdata = 16'h0000, coef_rdata, d1;
  logic        a_ib, a_no, a_bb, a_pd, a_by, a_fr, a_ae, a_cc, cascade;
  logic        b_ib, b_no, b_bb, b_pd, b_by, b_fr, b_ae, b_cc;
  logic [7:0]  a_val, b_val;
  logic [31:0] v;
  integer      seed = 95, n_mismatch = 0, checks_done = 0, i;
  wire  [7:0]  a_vec = {a_ib, a_no, a_bb, a_pd, a_by, a_fr, a_ae, a_cc};
  wire  [7:0]  b_vec = {b_ib, b_no, b_bb, b_pd, b_by, b_fr, b_ae, b_cc};
  localparam logic [7:0] AO = ctrl_one_pkg::A_CTRL_ONE_OFS, BO = ctrl_one_pkg::B_CTRL_ONE_OFS;

  // Clock at 10 MHz
  always #50 sys_clk = ~sys_clk;

  echo_group_control_reg1 #(.INIT_LEN(2)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_init_busy(a_ib), .a_noise_injection_off(a_no),
    .a_back_to_back_select(a_bb), .a_rx_pad_on(a_pd), .a_bypass(a_by), .a_adapt_freeze(a_fr),
    .a_adapt_enable(a_ae), .a_coef_clear(a_cc), .b_init_busy(b_ib), .b_noise_injection_off(b_no),
    .b_back_to_back_select(b_bb), .b_rx_pad_on(b_pd), .b_bypass(b_by), .b_adapt_freeze(b_fr),
    .b_adapt_enable(b_ae), .b_coef_clear(b_cc), .extended_delay_cascade(cascade),
    .coef_wr(coef_wr), .coef_addr(coef_addr), .coef_wdata(coef_wdata), .coef_rdata(coef_rdata));

  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  // Control outputs expected from a stored register value
  function automatic logic [7:0] ctl_exp(input logic [7:0] r);
    ctl_exp = {r[7], r[6], r[5], r[4], r[3], r[2], ~r[3] & ~r[2], r[3]};
  endfunction : ctl_exp

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Write cycle; strobe stays up so writes can follow with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
  endtask : wr

  task automatic idle();
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask : idle

  // Read cycle; data looked at in the one cycle it stands
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(name, {8'h00, reg_rdata}, {8'h00, exp});
    @(posedge sys_clk);
  endtask : rd

  task automatic coef_rw(input logic w, input logic [15:0] exp);
    coef_wr    <= w;
    coef_wdata <= d1;
    @(posedge sys_clk);
    coef_wr <= 1'b0;
    // Store takes the write, registered read shows it one cycle later
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("coef_rdata", coef_rdata, exp);
    @(posedge sys_clk);
  endtask : coef_rw

  task automatic results();
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    #(20000 * 100);
    n_mismatch = n_mismatch + 1;
    results();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd("a_reset", AO, ctrl_one_pkg::A_RESET_VALUE);
    rd("b_reset", BO, ctrl_one_pkg::B_RESET_VALUE);
    // Random settings, both copies, back-to-back bit equal, no cascade with it
    for (i = 0; i < 40; i = i + 1) begin
      v = $random(seed);
      a_val = {1'b0, v[6:2], 1'b0, v[8] & ~v[5]};
      if (i == 0) a_val = 8'h5D;
      if (i == 1) a_val = 8'h00;
      b_val = {1'b0, v[9], a_val[5], v[12:10], 2'b10};
      wr(AO, a_val);
      wr(BO, b_val);
      idle();
      chk("a_controls", {8'h00, a_vec}, {8'h00, ctl_exp(a_val)});
      chk("b_controls", {8'h00, b_vec}, {8'h00, ctl_exp(b_val)});
      chk("cascade", {15'h0000, cascade}, {15'h0000, a_val[0]});
      @(posedge sys_clk);
      rd("a_readback", AO, a_val);
      wr(v[31:24] | 8'h01, v[23:16]);
      rd("b_readback", BO, b_val);
      rd("unmapped", v[23:16] | 8'h01, 8'h00);
    end
    // Coefficients: adapt, freeze keeps old value, bypass clears
    d1 = v[15:0];
    coef_addr <= v[2:0];
    b_val[5] = 1'b0;
    wr(BO, b_val);
    wr(AO, 8'h00);
    coef_rw(1'b1, d1);
    d1 = ~v[15:0];
    wr(AO, 8'h04);
    coef_rw(1'b1, ~d1);
    wr(AO, 8'h08);
    coef_rw(1'b1, 16'h0000);
    wr(AO, 8'h00);
    coef_rw(1'b0, 16'h0000);
    // Initialisation with a refused write right behind it
    wr(AO, 8'hC4);
    wr(AO, 8'h5C);
    idle();
    chk("a_init_busy", {15'h0000, a_ib}, 16'h0001);
    for (i = 0; i < 10 && a_ib !== 1'b0; i = i + 1) @(negedge sys_clk);
    @(posedge sys_clk);
    rd("a_after_init", AO, ctrl_one_pkg::A_RESET_VALUE);
    chk("a_after_init_out", {8'h00, a_vec}, {8'h00, ctl_exp(ctrl_one_pkg::A_RESET_VALUE)});
    rd("b_untouched", BO, b_val);
    wr(BO, 8'h9E);
    idle();
    for (i = 0; i < 10 && b_ib !== 1'b0; i = i + 1) @(negedge sys_clk);
    @(posedge sys_clk);
    rd("b_after_init", BO, ctrl_one_pkg::B_RESET_VALUE);
    results();
  end
endmodule : test_echo_group_control_reg1
